// >>> sbr_defines.svh
`ifndef SBR_DEFINES_SVH
`define SBR_DEFINES_SVH

// ==========================================================================
// Address and request field layout
`define SBR_A_MSB 35
`define SBR_A_LSB 3
`define SBR_A_W 33
`define SBR_A20_BIT 20
`define SBR_A20_IDX 17
`define SBR_LANE_SPLIT_IDX 21
`define SBR_STB_SPLIT_IDX 17
`define SBR_REQ_W 5

// ==========================================================================
// Timing, in ns and in sys_clk cycles
`define SBR_SYS_NS 10
`define SBR_SETUP_NS 20
`define SBR_HOLD_NS 20
`define SBR_SETUP_CYC ((`SBR_SETUP_NS + `SBR_SYS_NS - 1) / `SBR_SYS_NS)
`define SBR_HOLD_CYC ((`SBR_HOLD_NS + `SBR_SYS_NS - 1) / `SBR_SYS_NS)

`endif

// >>> sbr_pkg.sv
`include "sbr_defines.svh"

package sbr_pkg;

   // =======================================================================
   // Types
   typedef logic [`SBR_A_W-1:0] sbr_addr_t;
   typedef logic [`SBR_REQ_W-1:0] sbr_req_t;

   // Gray along the request path
   typedef enum logic [2:0] {
      SBR_IDLE = 3'h0,
      SBR_P1_SET = 3'h1,
      SBR_P1_STB = 3'h3,
      SBR_P2_SET = 3'h2,
      SBR_P2_STB = 3'h6,
      SBR_ADS_HOLD = 3'h7
   } sbr_state_t;

endpackage : sbr_pkg

// >>> sbr_if.sv
`timescale 1ns/1ns
`include "sbr_defines.svh"

interface sbr_if;

   // =======================================================================
   // Bus clock, made by the bench
   logic bclk;

   // =======================================================================
   // Initiator drive side
   sbr_pkg::sbr_addr_t dev_addr_o;
   sbr_pkg::sbr_req_t dev_req_o;
   logic [1:0] dev_par_o;
   logic dev_ads_o;
   logic [1:0] dev_stb_o;
   logic dev_oe;

   // =======================================================================
   // Wire levels; undriven lines float high through termination
   sbr_pkg::sbr_addr_t addr_n;
   sbr_pkg::sbr_req_t req_n;
   logic [1:0] addr_parity_n;
   logic addr_valid_strobe_n;
   logic [1:0] addr_srcsync_strobe_n;

   assign addr_n = dev_oe ? dev_addr_o : '1;
   assign req_n = dev_oe ? dev_req_o : '1;
   assign addr_parity_n = dev_oe ? dev_par_o : 2'h3;
   assign addr_valid_strobe_n = dev_oe ? dev_ads_o : 1'b1;
   assign addr_srcsync_strobe_n = dev_oe ? dev_stb_o : 2'h3;

   // =======================================================================
   // Driven by the system side
   logic addr_bit20_mask_n;
   logic target_ready_n;

   modport dev_mp (
      input bclk,
      input addr_bit20_mask_n,
      output dev_addr_o,
      output dev_req_o,
      output dev_par_o,
      output dev_ads_o,
      output dev_stb_o,
      output dev_oe
   );

   modport peer_mp (
      input bclk,
      input addr_n,
      input req_n,
      input addr_parity_n,
      input addr_valid_strobe_n,
      input addr_srcsync_strobe_n,
      output addr_bit20_mask_n,
      output target_ready_n
   );

endinterface : sbr_if

// >>> sbr_parity.sv
`timescale 1ns/1ns
`include "sbr_defines.svh"

module sbr_parity (
   input wire sbr_pkg::sbr_addr_t addr_n,
   input wire sbr_pkg::sbr_req_t req_n,
   input wire logic phase2,
   output logic [1:0] par_n
);

   // =======================================================================
   // Lane coverage
   wire [`SBR_A_W-`SBR_LANE_SPLIT_IDX-1:0] hi_grp;
   wire [`SBR_LANE_SPLIT_IDX+`SBR_REQ_W-1:0] lo_grp;
   wire hi_par;
   wire lo_par;

   assign hi_grp = addr_n[`SBR_A_W-1:`SBR_LANE_SPLIT_IDX];
   assign lo_grp = {addr_n[`SBR_LANE_SPLIT_IDX-1:0], req_n};

   // High when an even number of lines sit low
   assign hi_par = ~(^(~hi_grp));
   assign lo_par = ~(^(~lo_grp));

   // Lanes swap between the two sub-phases
   assign par_n[0] = phase2 ? lo_par : hi_par;
   assign par_n[1] = phase2 ? hi_par : lo_par;

endmodule : sbr_parity

// >>> sbr_initiator.sv
`timescale 1ns/1ns
`include "sbr_defines.svh"


module sbr_initiator #(
   parameter int SETUP_CYC = `SBR_SETUP_CYC,
   parameter int HOLD_CYC = `SBR_HOLD_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   sbr_if.dev_mp bus,
   input wire logic req_valid,
   output logic req_ready,
   input wire sbr_pkg::sbr_addr_t req_addr,
   input wire sbr_pkg::sbr_addr_t req_attr,
   input wire sbr_pkg::sbr_req_t req_code1,
   input wire sbr_pkg::sbr_req_t req_code2,
   output sbr_pkg::sbr_addr_t issued_addr,
   output logic mask_active
);

   // =======================================================================
   // Parameter checks
   generate
      if (SETUP_CYC < 1 || SETUP_CYC > 8) begin : g_bad_setup
         $error("SETUP_CYC must lie in 1..8");
      end
      if (HOLD_CYC < 1 || HOLD_CYC > 8) begin : g_bad_hold
         $error("HOLD_CYC must lie in 1..8");
      end
   endgenerate

   localparam logic [2:0] SETUP_LAST = 3'(SETUP_CYC - 1);
   localparam logic [2:0] HOLD_LAST = 3'(HOLD_CYC - 1);

   // =======================================================================
   // Bus clock and mask synchronisers
   logic bclk_s1_q;
   logic bclk_s2_q;
   logic bclk_s3_q;
   logic mask_s1_q;
   logic mask_s2_q;
   wire bclk_rise;
   wire mask_on;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bclk_s1_q <= 1'b0;
         bclk_s2_q <= 1'b0;
         bclk_s3_q <= 1'b0;
         mask_s1_q <= 1'b1;
         mask_s2_q <= 1'b1;
      end else begin
         bclk_s1_q <= bus.bclk;
         bclk_s2_q <= bclk_s1_q;
         bclk_s3_q <= bclk_s2_q;
         mask_s1_q <= bus.addr_bit20_mask_n;
         mask_s2_q <= mask_s1_q;
      end
   end

   // Request starts and address-valid release happen on bus clock edges
   assign bclk_rise = bclk_s2_q & ~bclk_s3_q;
   assign mask_on = ~mask_s2_q;

   // =======================================================================
   // Address masking
   // Applied before the address leaves this block, so both the lookup
   // copy and the bus copy see the wrapped address.
   wire sbr_pkg::sbr_addr_t a20_clr;
   wire sbr_pkg::sbr_addr_t addr_masked;

   assign a20_clr = {{(`SBR_A_W-1){1'b0}}, mask_on} << `SBR_A20_IDX;
   assign addr_masked = req_addr & ~a20_clr;

   // =======================================================================
   // Request sequencer
   sbr_pkg::sbr_state_t state_q;
   sbr_pkg::sbr_state_t state_d;
   logic [2:0] cnt_q;
   logic [2:0] cnt_d;
   wire accept;
   wire cnt_done;

   assign accept = (state_q == sbr_pkg::SBR_IDLE) & req_valid & bclk_rise;
   assign req_ready = accept;
   assign cnt_done = (cnt_q == 3'h0);

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         sbr_pkg::SBR_IDLE: begin
            if (accept) begin
               state_d = sbr_pkg::SBR_P1_SET;
               cnt_d = SETUP_LAST;
            end
         end
         sbr_pkg::SBR_P1_SET: begin
            if (cnt_done) begin
               state_d = sbr_pkg::SBR_P1_STB;
               cnt_d = HOLD_LAST;
            end else begin
               cnt_d = cnt_q - 3'h1;
            end
         end
         sbr_pkg::SBR_P1_STB: begin
            if (cnt_done) begin
               state_d = sbr_pkg::SBR_P2_SET;
               cnt_d = SETUP_LAST;
            end else begin
               cnt_d = cnt_q - 3'h1;
            end
         end
         sbr_pkg::SBR_P2_SET: begin
            if (cnt_done) begin
               state_d = sbr_pkg::SBR_P2_STB;
               cnt_d = HOLD_LAST;
            end else begin
               cnt_d = cnt_q - 3'h1;
            end
         end
         sbr_pkg::SBR_P2_STB: begin
            if (cnt_done) begin
               state_d = sbr_pkg::SBR_ADS_HOLD;
            end else begin
               cnt_d = cnt_q - 3'h1;
            end
         end
         sbr_pkg::SBR_ADS_HOLD: begin
            // Held across a bus clock edge so every agent samples it
            if (bclk_rise) begin
               state_d = sbr_pkg::SBR_IDLE;
            end
         end
         default: begin
            state_d = sbr_pkg::SBR_IDLE;
            cnt_d = 3'h0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= sbr_pkg::SBR_IDLE;
         cnt_q <= 3'h0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // =======================================================================
   // Request capture
   sbr_pkg::sbr_addr_t addr_q;
   sbr_pkg::sbr_addr_t attr_q;
   sbr_pkg::sbr_req_t code1_q;
   sbr_pkg::sbr_req_t code2_q;
   logic mask_used_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         addr_q <= '0;
         attr_q <= '0;
         code1_q <= '0;
         code2_q <= '0;
         mask_used_q <= 1'b0;
      end else if (accept) begin
         addr_q <= addr_masked;
         attr_q <= req_attr;
         code1_q <= req_code1;
         code2_q <= req_code2;
         mask_used_q <= mask_on;
      end
   end

   assign issued_addr = addr_q;
   assign mask_active = mask_used_q;

   // =======================================================================
   // Pin drive
   wire busy_d;
   wire phase2_d;
   wire stb_low_d;
   wire sbr_pkg::sbr_addr_t pin_addr_d;
   wire sbr_pkg::sbr_req_t pin_req_d;
   wire [1:0] pin_par_d;
   // Accept cycle bypasses the capture flops, so the first beat under
   // address-valid already carries the new request, not the old one.
   wire sbr_pkg::sbr_addr_t first_addr;
   wire sbr_pkg::sbr_req_t first_code;

   assign busy_d = (state_d != sbr_pkg::SBR_IDLE);
   assign phase2_d = (state_d == sbr_pkg::SBR_P2_SET) |
                     (state_d == sbr_pkg::SBR_P2_STB) |
                     (state_d == sbr_pkg::SBR_ADS_HOLD);
   // Falling edge strobes sub-phase one, rising edge strobes sub-phase two, each after its setup
   assign stb_low_d = (state_d == sbr_pkg::SBR_P1_STB) |
                      (state_d == sbr_pkg::SBR_P2_SET);

   // Wires are active low: a set bit drives the line low
   assign first_addr = accept ? addr_masked : addr_q;
   assign first_code = accept ? req_code1 : code1_q;
   assign pin_addr_d = phase2_d ? ~attr_q : ~first_addr;
   assign pin_req_d = phase2_d ? ~code2_q : ~first_code;

   sbr_parity u_par (
      .addr_n(pin_addr_d),
      .req_n(pin_req_d),
      .phase2(phase2_d),
      .par_n(pin_par_d)
   );

   logic oe_q;
   logic ads_n_q;
   logic [1:0] stb_n_q;
   sbr_pkg::sbr_addr_t pin_addr_q;
   sbr_pkg::sbr_req_t pin_req_q;
   logic [1:0] pin_par_q;

   // All request pins move on one flop edge, so parity and
   // address-valid always accompany the lines they describe.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         oe_q <= 1'b0;
         ads_n_q <= 1'b1;
         stb_n_q <= 2'h3;
         pin_addr_q <= '1;
         pin_req_q <= '1;
         pin_par_q <= 2'h3;
      end else begin
         oe_q <= busy_d;
         ads_n_q <= ~busy_d;
         stb_n_q <= {2{~stb_low_d}};
         pin_addr_q <= pin_addr_d;
         pin_req_q <= pin_req_d;
         pin_par_q <= pin_par_d;
      end
   end

   assign bus.dev_oe = oe_q;
   assign bus.dev_ads_o = ads_n_q;
   assign bus.dev_stb_o = stb_n_q;
   assign bus.dev_addr_o = pin_addr_q;
   assign bus.dev_req_o = pin_req_q;
   assign bus.dev_par_o = pin_par_q;

endmodule : sbr_initiator

// >>> sbr_receiver.sv
`timescale 1ns/1ns
`include "sbr_defines.svh"

module sbr_receiver (
   input wire logic sys_clk,
   input wire logic rst,
   sbr_if.peer_mp bus,
   input wire logic mask_req,
   input wire logic io_write_done,
   output logic rx_ads_seen,
   output logic rx_valid,
   output sbr_pkg::sbr_addr_t rx_addr,
   output sbr_pkg::sbr_addr_t rx_attr,
   output sbr_pkg::sbr_req_t rx_code1,
   output sbr_pkg::sbr_req_t rx_code2,
   output logic rx_parity_err
);

   localparam int SW = `SBR_STB_SPLIT_IDX;

   // =======================================================================
   // Pin synchronisers
   sbr_pkg::sbr_addr_t a_s1_q;
   sbr_pkg::sbr_addr_t a_s2_q;
   sbr_pkg::sbr_req_t r_s1_q;
   sbr_pkg::sbr_req_t r_s2_q;
   logic [1:0] p_s1_q;
   logic [1:0] p_s2_q;
   logic [1:0] stb_s1_q;
   logic [1:0] stb_s2_q;
   logic [1:0] stb_s3_q;
   logic [1:0] ck_s_q;
   logic [1:0] ads_s_q;
   logic bclk_s3_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         a_s1_q <= '1;
         a_s2_q <= '1;
         r_s1_q <= '1;
         r_s2_q <= '1;
         p_s1_q <= 2'h3;
         p_s2_q <= 2'h3;
         stb_s1_q <= 2'h3;
         stb_s2_q <= 2'h3;
         stb_s3_q <= 2'h3;
         ck_s_q <= 2'h0;
         ads_s_q <= 2'h3;
         bclk_s3_q <= 1'b0;
      end else begin
         a_s1_q <= bus.addr_n;
         a_s2_q <= a_s1_q;
         r_s1_q <= bus.req_n;
         r_s2_q <= r_s1_q;
         p_s1_q <= bus.addr_parity_n;
         p_s2_q <= p_s1_q;
         stb_s1_q <= bus.addr_srcsync_strobe_n;
         stb_s2_q <= stb_s1_q;
         stb_s3_q <= stb_s2_q;
         ck_s_q <= {ck_s_q[0], bus.bclk};
         ads_s_q <= {ads_s_q[0], bus.addr_valid_strobe_n};
         bclk_s3_q <= ck_s_q[1];
      end
   end

   // =======================================================================
   // Address-valid sampled on bus clock edges, reported once
   wire bclk_rise;
   logic ads_rep_q;

   assign bclk_rise = ck_s_q[1] & ~bclk_s3_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ads_rep_q <= 1'b0;
         rx_ads_seen <= 1'b0;
      end else begin
         rx_ads_seen <= bclk_rise & ~ads_s_q[1] & ~ads_rep_q;
         if (ads_s_q[1]) begin
            ads_rep_q <= 1'b0;
         end else if (bclk_rise) begin
            ads_rep_q <= 1'b1;
         end
      end
   end

   // =======================================================================
   // Source-synchronous capture
   // Strobe 0 owns the low address slice, request lines and parity;
   // strobe 1 owns the high slice. Each edge carries one transfer.
   wire [1:0] stb_fall;
   wire [1:0] stb_rise;
   logic [1:0] got1_q;
   logic [1:0] got2_q;
   sbr_pkg::sbr_addr_t a1_q;
   sbr_pkg::sbr_addr_t a2_q;
   sbr_pkg::sbr_req_t r1_q;
   sbr_pkg::sbr_req_t r2_q;
   logic [1:0] p1_q;
   logic [1:0] p2_q;
   wire done;

   assign stb_fall = ~stb_s2_q & stb_s3_q;
   assign stb_rise = stb_s2_q & ~stb_s3_q;
   assign done = (&got1_q) & (&got2_q);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         a1_q <= '1;
         a2_q <= '1;
         r1_q <= '1;
         r2_q <= '1;
         p1_q <= 2'h3;
         p2_q <= 2'h3;
      end else begin
         if (stb_fall[0]) begin
            a1_q[SW-1:0] <= a_s2_q[SW-1:0];
            r1_q <= r_s2_q;
            p1_q <= p_s2_q;
         end
         if (stb_fall[1]) begin
            a1_q[`SBR_A_W-1:SW] <= a_s2_q[`SBR_A_W-1:SW];
         end
         if (stb_rise[0]) begin
            a2_q[SW-1:0] <= a_s2_q[SW-1:0];
            r2_q <= r_s2_q;
            p2_q <= p_s2_q;
         end
         if (stb_rise[1]) begin
            a2_q[`SBR_A_W-1:SW] <= a_s2_q[`SBR_A_W-1:SW];
         end
      end
   end

   // New edges win over the clear of a finished request
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         got1_q <= 2'h0;
         got2_q <= 2'h0;
      end else begin
         got1_q <= (got1_q & {2{~done}}) | stb_fall;
         got2_q <= (got2_q & {2{~done}}) | (stb_rise & got1_q);
      end
   end

   // =======================================================================
   // Parity check and delivery
   wire [1:0] calc1;
   wire [1:0] calc2;

   sbr_parity u_chk1 (
      .addr_n(a1_q),
      .req_n(r1_q),
      .phase2(1'b0),
      .par_n(calc1)
   );

   sbr_parity u_chk2 (
      .addr_n(a2_q),
      .req_n(r2_q),
      .phase2(1'b1),
      .par_n(calc2)
   );

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rx_valid <= 1'b0;
         rx_parity_err <= 1'b0;
         rx_addr <= '0;
         rx_attr <= '0;
         rx_code1 <= '0;
         rx_code2 <= '0;
      end else begin
         rx_valid <= done;
         rx_parity_err <= done & ((calc1 != p1_q) | (calc2 != p2_q));
         if (done) begin
            rx_addr <= ~a1_q;
            rx_attr <= ~a2_q;
            rx_code1 <= ~r1_q;
            rx_code2 <= ~r2_q;
         end
      end
   end

   // =======================================================================
   // Mask and target-ready leave on the same edge, so the mask is
   // already valid when target-ready of an I/O write is seen.
   logic mask_n_q;
   logic target_ready_n_n_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mask_n_q <= 1'b1;
         target_ready_n_n_q <= 1'b1;
      end else begin
         mask_n_q <= ~mask_req;
         target_ready_n_n_q <= ~io_write_done;
      end
   end

   assign bus.addr_bit20_mask_n = mask_n_q;
   assign bus.target_ready_n = target_ready_n_n_q;

endmodule : sbr_receiver

// >>> sbr_checker.sv
`timescale 1ns/1ns

module sbr_checker (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic bclk,
   input wire sbr_pkg::sbr_addr_t addr_n,
   input wire sbr_pkg::sbr_req_t req_n,
   input wire logic [1:0] addr_parity_n,
   input wire logic addr_valid_strobe_n,
   input wire logic [1:0] addr_srcsync_strobe_n
);

   // =======================================================================
   // Helper logic
   logic [1:0] par_p1;
   logic [1:0] par_p2;
   logic bclk_q;
   logic [7:0] bclk_age_q;
   logic [7:0] bclk_age_d;
   logic bclk_rise;
   logic age_full;

   // Lane high when the count of low lines is even
   assign par_p1 = {~^(~{addr_n[20:0], req_n}), ~^(~addr_n[32:21])};
   assign par_p2 = {par_p1[0], par_p1[1]};
   assign bclk_rise = bclk && !bclk_q;
   assign age_full = bclk_age_q == 8'hff;
   assign bclk_age_d = bclk_rise ? 8'h00 :
                       (age_full ? bclk_age_q : bclk_age_q + 8'h01);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bclk_q <= 1'b0;
         bclk_age_q <= 8'hff;
      end else begin
         bclk_q <= bclk;
         bclk_age_q <= bclk_age_d;
      end
   end

   // =======================================================================
   // Properties
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   sub1_parity_a: assert property (
      $fell(addr_srcsync_strobe_n[0]) |-> addr_parity_n == par_p1)
      else $error("parity wrong at first strobe edge");
   sub2_parity_a: assert property (
      $rose(addr_srcsync_strobe_n[0]) |-> addr_parity_n == par_p2)
      else $error("parity wrong at second strobe edge");
   lane_pair_a: assert property (
      !addr_valid_strobe_n |-> addr_parity_n == par_p1 ||
                               addr_parity_n == par_p2)
      else $error("parity not driven with address");
   idle_parity_a: assert property (
      (addr_n == '1) && (req_n == '1) |-> addr_parity_n == 2'h3)
      else $error("all-high lines must give high parity");
   fall_hold_a: assert property (
      $fell(addr_srcsync_strobe_n[1]) |->
         !addr_valid_strobe_n && $stable(addr_n) ##1 $stable(addr_n))
      else $error("address moved around strobe fall");
   rise_hold_a: assert property (
      $rose(addr_srcsync_strobe_n[1]) |->
         !addr_valid_strobe_n && $stable(addr_n) && $stable(req_n))
      else $error("address moved around strobe rise");
   strobe_idle_a: assert property (
      addr_valid_strobe_n |-> addr_srcsync_strobe_n == 2'h3)
      else $error("strobe toggled without address valid");
   ads_span_a: assert property (
      $fell(addr_valid_strobe_n) |-> !addr_valid_strobe_n [*8])
      else $error("address valid too short");
   ads_start_a: assert property (
      $fell(addr_valid_strobe_n) |-> bclk_age_q <= 8'h07)
      else $error("address valid not tied to bus clock");
   ads_end_a: assert property (
      $rose(addr_valid_strobe_n) |-> bclk_age_q <= 8'h07)
      else $error("address valid release not tied to bus clock");

endmodule : sbr_checker

// >>> testbench.sv
`timescale 1ns/1ns
`include "sbr_defines.svh"

module testbench;

   // =======================================================================
   // Stimulus and observed signals
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic bclk_tb = 1'b0;
   logic req_valid = 1'b0;
   logic req_ready, mask_active, rx_ads_seen, rx_valid, rx_parity_err;
   logic mask_req = 1'b0;
   logic io_write_done = 1'b0;
   logic r2_valid, r2_err;
   sbr_pkg::sbr_addr_t req_addr = '0;
   sbr_pkg::sbr_addr_t req_attr = '0;
   sbr_pkg::sbr_req_t req_code1 = '0;
   sbr_pkg::sbr_req_t req_code2 = '0;
   sbr_pkg::sbr_addr_t issued_addr, rx_addr, rx_attr, r2_addr;
   sbr_pkg::sbr_addr_t cap_a1, cap_a2;
   sbr_pkg::sbr_req_t rx_code1, rx_code2;
   logic [1:0] cap_p1, cap_p2, stb_q;
   logic [31:0] seed = 32'h83a30ed6;
   int mismatches = 0;
   int check_count = 0;
   int cycles = 0;
   int ads_seen_cnt = 0;

   always #5 sys_clk = ~sys_clk;
   // Bus clock free running, phase unrelated to sys_clk
   always begin
      #63 bclk_tb = ~bclk_tb;
      #62 bclk_tb = ~bclk_tb;
   end

   sbr_if i_sbr_if ();
   sbr_if i_sbr_if2 ();
   assign i_sbr_if.bclk = bclk_tb;
   assign i_sbr_if2.bclk = bclk_tb;

   sbr_initiator i_sbr_initiator (.sys_clk(sys_clk), .rst(rst),
      .bus(i_sbr_if.dev_mp), .req_valid(req_valid), .req_ready(req_ready),
      .req_addr(req_addr), .req_attr(req_attr), .req_code1(req_code1),
      .req_code2(req_code2), .issued_addr(issued_addr),
      .mask_active(mask_active));
   sbr_receiver i_sbr_receiver (.sys_clk(sys_clk), .rst(rst),
      .bus(i_sbr_if.peer_mp), .mask_req(mask_req),
      .io_write_done(io_write_done), .rx_ads_seen(rx_ads_seen),
      .rx_valid(rx_valid), .rx_addr(rx_addr), .rx_attr(rx_attr),
      .rx_code1(rx_code1), .rx_code2(rx_code2),
      .rx_parity_err(rx_parity_err));
   // Second receiver faces a deliberately faulty bench driver
   sbr_receiver i_sbr_receiver2 (.sys_clk(sys_clk), .rst(rst),
      .bus(i_sbr_if2.peer_mp), .mask_req(1'b0), .io_write_done(1'b0),
      .rx_ads_seen(), .rx_valid(r2_valid), .rx_addr(r2_addr), .rx_attr(),
      .rx_code1(), .rx_code2(), .rx_parity_err(r2_err));
   sbr_checker i_sbr_checker (.sys_clk(sys_clk), .rst(rst),
      .bclk(i_sbr_if.bclk), .addr_n(i_sbr_if.addr_n), .req_n(i_sbr_if.req_n),
      .addr_parity_n(i_sbr_if.addr_parity_n),
      .addr_valid_strobe_n(i_sbr_if.addr_valid_strobe_n),
      .addr_srcsync_strobe_n(i_sbr_if.addr_srcsync_strobe_n));

   // =======================================================================
   // Wire capture at strobe edges
   always @(posedge sys_clk) begin
      stb_q <= i_sbr_if.addr_srcsync_strobe_n;
      if (stb_q == 2'h3 && i_sbr_if.addr_srcsync_strobe_n == 2'h0) begin
         cap_a1 <= i_sbr_if.addr_n;
         cap_p1 <= i_sbr_if.addr_parity_n;
      end
      if (stb_q == 2'h0 && i_sbr_if.addr_srcsync_strobe_n == 2'h3) begin
         cap_a2 <= i_sbr_if.addr_n;
         cap_p2 <= i_sbr_if.addr_parity_n;
      end
      if (rx_ads_seen === 1'b1) ads_seen_cnt <= ads_seen_cnt + 1;
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   // =======================================================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
   endfunction : lfsr

   function automatic logic [1:0] wire_par(input sbr_pkg::sbr_addr_t a_n,
         input sbr_pkg::sbr_req_t r_n, input logic ph2);
      logic hi;
      logic lo;
      hi = ~^(~a_n[32:21]);
      lo = ~^(~{a_n[20:0], r_n});
      wire_par = ph2 ? {hi, lo} : {lo, hi};
   endfunction : wire_par

   task automatic draw(output logic [32:0] v);
      seed = lfsr(seed);
      v[31:0] = seed;
      seed = lfsr(seed);
      v[32] = seed[0];
   endtask : draw

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : tally_and_finish

   task automatic run_txn(input logic [32:0] a, input logic [32:0] t,
         input logic [4:0] c1, input logic [4:0] c2, input logic m);
      sbr_pkg::sbr_addr_t exp_a;
      int n;
      int seen0;
      exp_a = a;
      if (m) exp_a[`SBR_A20_IDX] = 1'b0;
      mask_req = m;
      repeat (6) @(negedge sys_clk);
      seen0 = ads_seen_cnt;
      req_addr = a;
      req_attr = t;
      req_code1 = c1;
      req_code2 = c2;
      req_valid = 1'b1;
      n = 0;
      #2;
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         #2;
         n++;
      end
      check(req_ready, 1'b1);
      @(negedge sys_clk);
      req_valid = 1'b0;
      check(issued_addr, exp_a);
      check(mask_active, m);
      n = 0;
      while (rx_valid !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      check(rx_valid, 1'b1);
      check(rx_addr, exp_a);
      check(rx_attr, t);
      check({rx_code2, rx_code1}, {c2, c1});
      check(rx_parity_err, 1'b0);
      check(cap_a1, ~exp_a);
      check(cap_p1, wire_par(~exp_a, ~c1, 1'b0));
      check(cap_a2, ~t);
      check(cap_p2, wire_par(~t, ~c2, 1'b1));
      n = 0;
      while (i_sbr_if.addr_valid_strobe_n !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      check(i_sbr_if.addr_valid_strobe_n, 1'b1);
      repeat (6) @(negedge sys_clk);
      check(ads_seen_cnt - seen0, 1);
      check(i_sbr_if.addr_parity_n, 2'h3);
   endtask : run_txn

   // Drives the second bus by hand, flipping parity lanes on request
   task automatic bad_txn(input logic [32:0] a, input logic [4:0] c,
         input logic [1:0] f1, input logic [1:0] f2, input logic e);
      int n;
      @(negedge sys_clk);
      i_sbr_if2.dev_oe = 1'b1;
      i_sbr_if2.dev_ads_o = 1'b0;
      i_sbr_if2.dev_addr_o = ~a;
      i_sbr_if2.dev_req_o = ~c;
      i_sbr_if2.dev_par_o = wire_par(~a, ~c, 1'b0) ^ f1;
      repeat (3) @(negedge sys_clk);
      i_sbr_if2.dev_stb_o = 2'h0;
      repeat (3) @(negedge sys_clk);
      i_sbr_if2.dev_addr_o = a;
      i_sbr_if2.dev_req_o = c;
      i_sbr_if2.dev_par_o = wire_par(a, c, 1'b1) ^ f2;
      repeat (3) @(negedge sys_clk);
      i_sbr_if2.dev_stb_o = 2'h3;
      n = 0;
      while (r2_valid !== 1'b1 && n < 50) begin
         @(negedge sys_clk);
         n++;
      end
      check(r2_valid, 1'b1);
      check(r2_err, e);
      check(r2_addr, a);
      @(posedge bclk_tb);
      repeat (2) @(negedge sys_clk);
      i_sbr_if2.dev_oe = 1'b0;
      i_sbr_if2.dev_ads_o = 1'b1;
      repeat (4) @(negedge sys_clk);
   endtask : bad_txn

   // =======================================================================
   // Main sequence
   initial begin
      logic [32:0] a;
      logic [32:0] t;
      logic [32:0] c;
      i_sbr_if2.dev_oe = 1'b0;
      i_sbr_if2.dev_ads_o = 1'b1;
      i_sbr_if2.dev_stb_o = 2'h3;
      i_sbr_if2.dev_addr_o = '1;
      i_sbr_if2.dev_req_o = '1;
      i_sbr_if2.dev_par_o = 2'h3;
      repeat (20) @(negedge sys_clk);
      rst = 1'b0;
      mask_req = 1'b1;
      io_write_done = 1'b1;
      @(negedge sys_clk);
      check(i_sbr_if.target_ready_n, 1'b0);
      check(i_sbr_if.addr_bit20_mask_n, 1'b0);
      io_write_done = 1'b0;
      @(negedge sys_clk);
      check(i_sbr_if.target_ready_n, 1'b1);
      run_txn('1, '1, 5'h1f, 5'h1f, 1'b0);
      run_txn('0, '0, 5'h00, 5'h00, 1'b0);
      a = 33'h1 << `SBR_A20_IDX;
      run_txn(a, '1, 5'h15, 5'h0a, 1'b1);
      run_txn(a, '0, 5'h0a, 5'h15, 1'b0);
      for (int i = 0; i < 10; i++) begin
         draw(a);
         draw(t);
         draw(c);
         run_txn(a, t, c[4:0], c[9:5], c[10]);
      end
      draw(a);
      bad_txn(a, a[4:0], 2'h0, 2'h0, 1'b0);
      bad_txn(a, a[4:0], 2'h1, 2'h0, 1'b1);
      bad_txn(a, a[4:0], 2'h0, 2'h2, 1'b1);
      tally_and_finish();
   end

endmodule : testbench
